// file: bench/hsp_host_model.sv
// Host controller model driving the SPI and I2C pins of the block
`timescale 1ns/1ps
module hsp_host_model (
  output logic spiClk,
  output logic spiSelectN,
  output logic spiDataIn,
  input wire logic spiDataOut,
  output logic i2cScl,
  output wire logic i2cSdaIn,
  input wire logic i2cSdaOut,
  input wire logic i2cSdaOeN
);
  localparam int Q = 125;
  logic sdaM;
  // Pulled-up data wire: low when either party pulls it
  assign i2cSdaIn = sdaM & (i2cSdaOeN | i2cSdaOut);
  initial begin
    spiClk = 1'b0;
    spiSelectN = 1'b1;
    spiDataIn = 1'b0;
    i2cScl = 1'b1;
    sdaM = 1'b1;
  end
  // One frame; serial clock runs only inside it
  task automatic spiXfer(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    spiSelectN = 1'b0;
    #48;
    for (int i = 15; i >= 0; i--) begin
      spiDataIn = w[i];
      #24;
      if (i < 8) r = {r[6:0], spiDataOut};
      spiClk = 1'b1;
      #24;
      spiClk = 1'b0;
    end
    spiDataIn = ~w[0];
    #48;
    spiSelectN = 1'b1;
    #100;
  endtask : spiXfer
  task automatic selFlip();
    spiSelectN = ~spiSelectN;
  endtask : selFlip
  task automatic i2cStart();
    sdaM = 1'b1;
    #Q i2cScl = 1'b1;
    #Q sdaM = 1'b0;
    #Q i2cScl = 1'b0;
    #Q;
  endtask : i2cStart
  task automatic i2cStop();
    sdaM = 1'b0;
    #Q i2cScl = 1'b1;
    #Q sdaM = 1'b1;
    #Q;
  endtask : i2cStop
  task automatic i2cBit(input logic b, output logic s);
    sdaM = b;
    #Q i2cScl = 1'b1;
    #Q s = i2cSdaIn;
    #Q i2cScl = 1'b0;
    #Q;
  endtask : i2cBit
  // Eight bits then the ninth clock; m is what the host leaves on the wire
  task automatic i2cByte(input logic [7:0] w, input logic m, output logic [7:0] r,
                         output logic ack);
    for (int i = 7; i >= 0; i--) i2cBit(w[i], r[i]);
    i2cBit(m, ack);
    ack = ~ack;
  endtask : i2cByte
endmodule : hsp_host_model

// file: bench/hsp_top_tb_top.sv
// Self-checking testbench for the host serial port block
`timescale 1ns/1ps
`define CHK(a, e, m) begin \
  checked++; \
  if ((a) !== (e)) begin \
    nMismatch++; \
    $display("unexpected at %0t: %s got %h exp %h", $time, m, a, e); \
  end \
end
module hsp_top_tb_top;
  logic clk, rst, enableIoSupplyPin, ifSelect, faultIn;
  wire spiClk, spiSelectN, spiDataIn, spiDataOut, spiDataOeN;
  wire i2cScl, i2cSdaIn, i2cSdaOut, i2cSdaOeN;
  wire plSwitchOn, boostOn, sinksOn, faultClear, ifIsSpi;
  int nMismatch = 0;
  int checked = 0;
  logic [7:0] d;
  logic k, seen;
  hsp_top #(.SOFT_CYC(400), .BOOST_CYC(400), .REC_CYC(2000), .NVM_BYTES(25)) u_hsp_top (
    .clk(clk), .rst(rst), .enableIoSupplyPin(enableIoSupplyPin), .ifSelect(ifSelect),
    .faultIn(faultIn), .spiClk(spiClk), .spiSelectN(spiSelectN), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut), .spiDataOeN(spiDataOeN), .i2cScl(i2cScl),
    .i2cSdaIn(i2cSdaIn), .i2cSdaOut(i2cSdaOut), .i2cSdaOeN(i2cSdaOeN),
    .plSwitchOn(plSwitchOn), .boostOn(boostOn), .sinksOn(sinksOn),
    .faultClear(faultClear), .ifIsSpi(ifIsSpi));
  hsp_host_model u_hsp_host_model (
    .spiClk(spiClk), .spiSelectN(spiSelectN), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut), .i2cScl(i2cScl), .i2cSdaIn(i2cSdaIn),
    .i2cSdaOut(i2cSdaOut), .i2cSdaOeN(i2cSdaOeN));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic spiWr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] r;
    u_hsp_host_model.spiXfer({a, 1'b1, v}, r);
  endtask : spiWr
  task automatic spiRd(input logic [6:0] a, output logic [7:0] v);
    u_hsp_host_model.spiXfer({a, 1'b0, 8'h00}, v);
  endtask : spiRd
  task automatic i2cWr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    logic ack;
    u_hsp_host_model.i2cStart();
    u_hsp_host_model.i2cByte(8'h5a, 1'b1, r, ack);
    `CHK(ack, 1'b1, "address ack")
    u_hsp_host_model.i2cByte(a, 1'b1, r, ack);
    u_hsp_host_model.i2cByte(v, 1'b1, r, ack);
    `CHK(ack, 1'b1, "data ack")
    u_hsp_host_model.i2cStop();
  endtask : i2cWr
  task automatic i2cRd(input logic [7:0] a, output logic [7:0] v);
    logic ack;
    u_hsp_host_model.i2cStart();
    u_hsp_host_model.i2cByte(8'h5a, 1'b1, v, ack);
    u_hsp_host_model.i2cByte(a, 1'b1, v, ack);
    `CHK(ack, 1'b1, "register ack")
    u_hsp_host_model.i2cStart();
    u_hsp_host_model.i2cByte(8'h5b, 1'b1, v, ack);
    `CHK(ack, 1'b1, "read address ack")
    u_hsp_host_model.i2cByte(8'hff, 1'b1, v, ack);
    u_hsp_host_model.i2cStop();
  endtask : i2cRd
  task automatic waitRun();
    for (int n = 0; n < 5000 && sinksOn !== 1'b1; n++) @(posedge clk);
    #1;
    `CHK(boostOn, 1'b1, "boost on in run")
  endtask : waitRun
  task automatic powerCycle(input logic sel);
    @(posedge clk);
    enableIoSupplyPin <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    `CHK(plSwitchOn, 1'b0, "standby switch")
    @(posedge clk);
    ifSelect <= sel;
    enableIoSupplyPin <= 1'b1;
    waitRun();
  endtask : powerCycle
  task automatic unlock();
    spiWr(7'h00, 8'h00);
    spiWr(7'h1a, 8'h08);
    spiWr(7'h1a, 8'hba);
    spiWr(7'h1a, 8'hef);
  endtask : unlock
  initial begin
    #300000;
    nMismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    enableIoSupplyPin = 1'b0;
    ifSelect = 1'b1;
    faultIn = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHK(spiDataOeN, 1'b1, "miso released")
    `CHK(plSwitchOn, 1'b0, "standby")
    @(posedge clk);
    enableIoSupplyPin <= 1'b1;
    for (int n = 0; n < 100 && plSwitchOn !== 1'b1; n++) @(posedge clk);
    #1;
    `CHK(boostOn, 1'b0, "boost waits for soft start")
    spiWr(7'h03, 8'ha5);
    waitRun();
    `CHK(plSwitchOn, 1'b1, "switch on in run")
    spiRd(7'h03, d);
    `CHK(d, 8'h00, "early write dropped")
    spiRd(7'h18, d);
    `CHK(d, 8'h14, "status spi run")
    `CHK(ifIsSpi, 1'b1, "strap spi")
    spiWr(7'h03, 8'h5a);
    spiRd(7'h03, d);
    `CHK(d, 8'h5a, "spi readback")
    repeat (5) @(posedge clk);
    #1;
    `CHK(spiDataOeN, 1'b1, "miso released after frame")
    spiWr(7'h60, 8'h3c);
    spiRd(7'h60, d);
    `CHK(d, 8'h00, "locked config write")
    unlock();
    spiRd(7'h18, d);
    `CHK(d, 8'h1c, "unlocked status")
    spiWr(7'h60, 8'h3c);
    spiRd(7'h60, d);
    `CHK(d, 8'h3c, "config write")
    spiWr(7'h19, 8'h01);
    repeat (50) @(posedge clk);
    spiWr(7'h61, 8'h77);
    spiWr(7'h1a, 8'h00);
    spiRd(7'h18, d);
    `CHK(d, 8'h14, "relocked status")
    spiWr(7'h61, 8'h11);
    spiRd(7'h61, d);
    `CHK(d, 8'h77, "write after relock")
    powerCycle(1'b1);
    spiRd(7'h61, d);
    `CHK(d, 8'h00, "unburned value lost")
    unlock();
    spiWr(7'h60, 8'h99);
    spiRd(7'h60, d);
    `CHK(d, 8'h99, "front-end overwrite")
    spiWr(7'h19, 8'h02);
    repeat (50) @(posedge clk);
    spiRd(7'h60, d);
    `CHK(d, 8'h3c, "burned value loaded")
    spiWr(7'h1a, 8'h00);
    @(posedge clk);
    faultIn <= 1'b1;
    repeat (10) @(posedge clk);
    faultIn <= 1'b0;
    #1;
    `CHK({plSwitchOn, boostOn, sinksOn}, 3'b000, "recovery outputs")
    spiRd(7'h18, d);
    `CHK(d, 8'h15, "status in recovery")
    waitRun();
    powerCycle(1'b0);
    @(posedge clk);
    ifSelect <= 1'b1;
    i2cRd(8'h18, d);
    `CHK(d, 8'h04, "status i2c run")
    `CHK(ifIsSpi, 1'b0, "strap i2c")
    i2cWr(8'h02, 8'hc3);
    i2cRd(8'h02, d);
    `CHK(d, 8'hc3, "i2c readback")
    `CHK(i2cSdaOeN, 1'b1, "sda released after nack")
    `CHK(i2cSdaOut, 1'b0, "sda pulls low only")
    u_hsp_host_model.i2cStart();
    u_hsp_host_model.i2cByte(8'h5a, 1'b1, d, k);
    u_hsp_host_model.i2cByte(8'h02, 1'b1, d, k);
    for (int i = 0; i < 4; i++) u_hsp_host_model.i2cBit(1'b0, k);
    u_hsp_host_model.i2cStop();
    i2cRd(8'h02, d);
    `CHK(d, 8'hc3, "aborted write")
    u_hsp_host_model.i2cStart();
    u_hsp_host_model.i2cByte(8'h58, 1'b1, d, k);
    `CHK(k, 1'b0, "foreign address")
    u_hsp_host_model.i2cStop();
    seen = 1'b0;
    u_hsp_host_model.selFlip();
    repeat (10) begin
      @(posedge clk);
      #1;
      if (faultClear === 1'b1) seen = 1'b1;
    end
    `CHK(seen, 1'b1, "fault clear pulse")
    u_hsp_host_model.selFlip();
    repeat (10) @(posedge clk);
    wrap_up();
  end
endmodule : hsp_top_tb_top

// file: design/hsp_pkg.sv
// Constants and types for the host serial port and NVM access block
package hsp_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RECOVERY_MS = 100;
  localparam int unsigned RECOVERY_CYC = RECOVERY_MS * 1000 * CLK_MHZ;
  localparam int unsigned SOFT_START_US = 1000;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int unsigned BOOST_START_US = 1000;
  localparam int unsigned BOOST_START_CYC = BOOST_START_US * CLK_MHZ;
  localparam int unsigned NVM_BYTES = 25;

  localparam logic [6:0] WORK_REGS = 7'h18;
  localparam logic [6:0] STATUS_ADDR = 7'h18;
  localparam logic [6:0] NVM_CMD_ADDR = 7'h19;
  localparam logic [6:0] UNLOCK_ADDR = 7'h1a;
  localparam logic [6:0] CFG_BASE = 7'h60;
  localparam int unsigned CMD_BURN_BIT = 0;
  localparam int unsigned CMD_LOAD_BIT = 1;
  localparam logic [7:0] NVM_RESET_VAL = 8'h00;

  localparam logic [7:0] PASS0 = 8'h08;
  localparam logic [7:0] PASS1 = 8'hba;
  localparam logic [7:0] PASS2 = 8'hef;
  localparam logic [1:0] UNLOCKED = 2'h3;

  localparam logic [6:0] DEV_ADDR = 7'h2d;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  localparam logic [4:0] SPI_ADDR_LAST = 5'h06;
  localparam logic [4:0] SPI_DIR = 5'h07;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h08;
  localparam logic [4:0] SPI_LAST = 5'h0f;
  localparam logic [4:0] SPI_END = 5'h10;

  typedef enum logic [2:0] {MD_STBY, MD_LOAD, MD_SOFT, MD_BOOST, MD_RUN, MD_RECOV} hsp_mode_type;
  typedef enum logic [2:0] {IC_IDLE, IC_RX, IC_ACK, IC_TX, IC_TXACK} hsp_i2c_type;
  typedef enum logic [1:0] {PH_DEV, PH_REG, PH_DATA} hsp_phase_type;
endpackage : hsp_pkg

// file: design/hsp_top.sv
// Host serial port, operating modes and guarded NVM configuration access
// Functional notes
// - Enable pin low keeps the block in standby with logic inactive.
// - Start-up copies NVM into registers, then power switch, then boost.
// - Host transactions and register changes accepted only after soft start; here also in recovery, even when entered during soft start.
// - Recovery turns off power switch, boost and sinks; serial port stays usable.
// - Configuration store is 25 bytes behind a host-visible register front-end.
// - Front-end values are lost on reset or enable cycling unless burned; reset here also clears the NVM store, so burned values are lost too.
// - NVM read and NVM burn each need their own explicit host command.
// - Pass-code sequence unlocks command and configuration registers for writing.
// - Any other value written to the unlock register locks again at once.
// - Interface select pin sampled at start-up only; later changes ignored.
// - SPI cycle is 16 bits: 7 address, direction, 8 data, MSB first.
// - SPI direction bit high means write, low means read.
// - SPI output released while select high, else low except read data.
// - Select low for a whole cycle; high resets SPI receive logic.
// - SPI inputs captured on rising clock edges, outputs on falling edges.
// - I2C samples SDA while SCL high; SDA change then aborts a transaction.
// - SDA fall with SCL high is start, SDA rise is stop.
// - Each I2C byte has 8 bits MSB first plus one acknowledge bit.
// - Repeated start mid-transaction turns around into a register read.
// - On the ninth clock the receiver holds SDA low to acknowledge.
// - Master leaving SDA high after last read byte stops slave driving.
// - I2C slave answers address 2Dh; eighth bit one reads, zero writes.
// - I2C write is address, register address, data, each acked, then stop.
// - In I2C mode a select pin level change clears faults.
`timescale 1ns/1ps

module hsp_top #(
  parameter int unsigned SOFT_CYC = hsp_pkg::SOFT_START_CYC,
  parameter int unsigned BOOST_CYC = hsp_pkg::BOOST_START_CYC,
  parameter int unsigned REC_CYC = hsp_pkg::RECOVERY_CYC,
  parameter int unsigned NVM_BYTES = hsp_pkg::NVM_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enableIoSupplyPin,
  input wire logic ifSelect,
  input wire logic faultIn,
  input wire logic spiClk,
  input wire logic spiSelectN,
  input wire logic spiDataIn,
  output logic spiDataOut,
  output logic spiDataOeN,
  input wire logic i2cScl,
  input wire logic i2cSdaIn,
  output logic i2cSdaOut,
  output logic i2cSdaOeN,
  output logic plSwitchOn,
  output logic boostOn,
  output logic sinksOn,
  output logic faultClear,
  output logic ifIsSpi
);

  hsp_pkg::hsp_mode_type stQ;
  hsp_pkg::hsp_i2c_type iStQ;
  hsp_pkg::hsp_phase_type iPhQ;
  logic [31:0] tmrQ;
  logic [7:0] s1Q, s2Q;
  logic [4:0] s3Q;
  logic enS, ifSelS, faultS, selS, sclS, sdaS, rdTS, wrTS;
  logic selP, sclP, sdaP, rdTP, wrTP;
  logic [7:0] workQ [hsp_pkg::WORK_REGS];
  logic [7:0] cfgQ [NVM_BYTES];
  logic [7:0] nvmQ [NVM_BYTES];
  logic [1:0] unlockQ;
  logic unlocked, accessOk, ifSpiQ;
  logic [4:0] sCntQ;
  logic [6:0] sShQ, sAddrQ;
  logic [7:0] sDataQ, rdWordQ;
  logic sDirQ, rdTogQ, wrTogQ, misoQ;
  logic [3:0] iCntQ;
  logic [7:0] iShQ, iAddrQ, txByte, statusByte, passNext;
  logic iRwQ, sdaOeNQ, sdaOutQ;
  logic plOnQ, boostOnQ, sinksOnQ, faultClearQ, spiOeNQ;
  logic sclRise, sclFall, startC, stopC, i2cWr;
  logic wrEn, doWr, inCfg, cmdWr, burnFire, loadFire;
  logic [6:0] wrAddr;
  logic [7:0] wrData;

  // Pin and toggle synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Q <= 8'h00;
      s2Q <= 8'h00;
      s3Q <= 5'h00;
    end else begin
      s1Q <= {enableIoSupplyPin, ifSelect, faultIn, spiSelectN, i2cScl, i2cSdaIn, rdTogQ, wrTogQ};
      s2Q <= s1Q;
      s3Q <= s2Q[4:0];
    end
  end
  assign {enS, ifSelS, faultS, selS, sclS, sdaS, rdTS, wrTS} = s2Q;
  assign {selP, sclP, sdaP, rdTP, wrTP} = s3Q;

  // Operating mode sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stQ <= hsp_pkg::MD_STBY;
      tmrQ <= 32'h0;
    end else if (!enS) begin
      stQ <= hsp_pkg::MD_STBY;
      tmrQ <= 32'h0;
    end else begin
      tmrQ <= tmrQ + 32'h1;
      case (stQ)
        hsp_pkg::MD_STBY: stQ <= hsp_pkg::MD_LOAD;
        hsp_pkg::MD_LOAD: begin
          stQ <= hsp_pkg::MD_SOFT;
          tmrQ <= 32'h0;
        end
        hsp_pkg::MD_SOFT: begin
          if (faultS) begin
            stQ <= hsp_pkg::MD_RECOV;
            tmrQ <= 32'h0;
          end else if (tmrQ == SOFT_CYC - 1) begin
            stQ <= hsp_pkg::MD_BOOST;
            tmrQ <= 32'h0;
          end
        end
        hsp_pkg::MD_BOOST: begin
          if (faultS) begin
            stQ <= hsp_pkg::MD_RECOV;
            tmrQ <= 32'h0;
          end else if (tmrQ == BOOST_CYC - 1) begin
            stQ <= hsp_pkg::MD_RUN;
            tmrQ <= 32'h0;
          end
        end
        hsp_pkg::MD_RUN: begin
          tmrQ <= 32'h0;
          if (faultS) stQ <= hsp_pkg::MD_RECOV;
        end
        hsp_pkg::MD_RECOV: begin
          if (tmrQ == REC_CYC - 1) begin
            stQ <= hsp_pkg::MD_SOFT;
            tmrQ <= 32'h0;
          end
        end
        default: stQ <= hsp_pkg::MD_STBY;
      endcase
    end
  end

  // Soft start done; recovery keeps the port open for fault reads
  assign accessOk = stQ inside {hsp_pkg::MD_BOOST, hsp_pkg::MD_RUN, hsp_pkg::MD_RECOV};

  // Interface strap, caught once per start-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ifSpiQ <= 1'b0;
    else if (stQ == hsp_pkg::MD_LOAD) ifSpiQ <= ifSelS;
  end

  // Pin outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      plOnQ <= 1'b0;
      boostOnQ <= 1'b0;
      sinksOnQ <= 1'b0;
      faultClearQ <= 1'b0;
      spiOeNQ <= 1'b1;
      sdaOutQ <= 1'b0;
    end else begin
      plOnQ <= stQ inside {hsp_pkg::MD_SOFT, hsp_pkg::MD_BOOST, hsp_pkg::MD_RUN};
      boostOnQ <= stQ inside {hsp_pkg::MD_BOOST, hsp_pkg::MD_RUN};
      sinksOnQ <= stQ == hsp_pkg::MD_RUN;
      faultClearQ <= !ifSpiQ && stQ != hsp_pkg::MD_STBY && (selS ^ selP);
      spiOeNQ <= !ifSpiQ || selS || stQ == hsp_pkg::MD_STBY;
      sdaOutQ <= 1'b0;
    end
  end

  // Register read view
  assign statusByte = {3'h0, ifSpiQ, unlocked, stQ};
  function automatic logic [7:0] rdByte(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a < hsp_pkg::WORK_REGS) v = workQ[a[4:0]];
    else if (a >= hsp_pkg::CFG_BASE && (a - hsp_pkg::CFG_BASE) < 7'(NVM_BYTES))
      v = cfgQ[5'(a - hsp_pkg::CFG_BASE)];
    else if (a == hsp_pkg::STATUS_ADDR) v = statusByte;
    return v;
  endfunction : rdByte

  // Write port shared by both interfaces
  assign i2cWr = iStQ == hsp_pkg::IC_RX && sclFall && iCntQ == hsp_pkg::BYTE_BITS
    && iPhQ == hsp_pkg::PH_DATA;
  always_comb begin
    if (ifSpiQ) begin
      wrEn = wrTS ^ wrTP;
      wrAddr = sAddrQ;
      wrData = sDataQ;
    end else begin
      wrEn = i2cWr && !iAddrQ[7];
      wrAddr = iAddrQ[6:0];
      wrData = iShQ;
    end
  end
  assign doWr = wrEn && accessOk;
  assign unlocked = unlockQ == hsp_pkg::UNLOCKED;
  assign inCfg = wrAddr >= hsp_pkg::CFG_BASE && (wrAddr - hsp_pkg::CFG_BASE) < 7'(NVM_BYTES);
  assign cmdWr = doWr && unlocked && wrAddr == hsp_pkg::NVM_CMD_ADDR;
  assign burnFire = cmdWr && wrData[hsp_pkg::CMD_BURN_BIT];
  assign loadFire = cmdWr && wrData[hsp_pkg::CMD_LOAD_BIT] && !burnFire;

  // Working registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) workQ <= '{default: 8'h00};
    else if (stQ == hsp_pkg::MD_STBY) workQ <= '{default: 8'h00};
    else if (doWr && wrAddr < hsp_pkg::WORK_REGS) workQ[wrAddr[4:0]] <= wrData;
  end

  // Configuration front-end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfgQ <= '{default: 8'h00};
    else if (stQ == hsp_pkg::MD_STBY) cfgQ <= '{default: 8'h00};
    else if (stQ == hsp_pkg::MD_LOAD || loadFire) cfgQ <= nvmQ;
    else if (doWr && unlocked && inCfg) cfgQ[5'(wrAddr - hsp_pkg::CFG_BASE)] <= wrData;
  end

  // Non-volatile store, kept across enable cycling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) nvmQ <= '{default: hsp_pkg::NVM_RESET_VAL};
    else if (burnFire) nvmQ <= cfgQ;
  end

  // Pass-code lock
  assign passNext = unlockQ == 2'h0 ? hsp_pkg::PASS0 :
    unlockQ == 2'h1 ? hsp_pkg::PASS1 : hsp_pkg::PASS2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) unlockQ <= 2'h0;
    else if (stQ == hsp_pkg::MD_STBY) unlockQ <= 2'h0;
    else if (doWr && wrAddr == hsp_pkg::UNLOCK_ADDR) begin
      if (!unlocked && wrData == passNext) unlockQ <= unlockQ + 2'h1;
      else if (wrData == hsp_pkg::PASS0) unlockQ <= 2'h1;
      else unlockQ <= 2'h0;
    end
  end

  // SPI receive shifter, cleared while select is high
  always_ff @(posedge spiClk or posedge rst or posedge spiSelectN) begin
    if (rst || spiSelectN) begin
      sCntQ <= 5'h00;
      sShQ <= 7'h00;
      sDirQ <= 1'b0;
    end else begin
      sShQ <= {sShQ[5:0], spiDataIn};
      if (sCntQ != hsp_pkg::SPI_END) sCntQ <= sCntQ + 5'h01;
      if (sCntQ == hsp_pkg::SPI_DIR) sDirQ <= spiDataIn;
    end
  end

  // Address and data handed over with toggles; words stay put until the next cycle
  always_ff @(posedge spiClk or posedge rst) begin
    if (rst) begin
      sAddrQ <= 7'h00;
      sDataQ <= 8'h00;
      rdTogQ <= 1'b0;
      wrTogQ <= 1'b0;
    end else if (!spiSelectN) begin
      if (sCntQ == hsp_pkg::SPI_ADDR_LAST) begin
        sAddrQ <= {sShQ[5:0], spiDataIn};
        rdTogQ <= !rdTogQ;
      end
      if (sCntQ == hsp_pkg::SPI_LAST && sDirQ) begin
        sDataQ <= {sShQ, spiDataIn};
        wrTogQ <= !wrTogQ;
      end
    end
  end

  // Read word settles well before its first falling-edge launch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdWordQ <= 8'h00;
    else if (rdTS ^ rdTP) rdWordQ <= accessOk ? rdByte(sAddrQ) : 8'h00;
  end

  always_ff @(negedge spiClk or posedge rst or posedge spiSelectN) begin
    if (rst || spiSelectN) misoQ <= 1'b0;
    else if (!sDirQ && sCntQ >= hsp_pkg::SPI_DATA_FIRST && sCntQ < hsp_pkg::SPI_END)
      misoQ <= rdWordQ[3'(hsp_pkg::SPI_LAST - sCntQ)];
    else misoQ <= 1'b0;
  end

  // I2C slave
  assign sclRise = sclS && !sclP;
  assign sclFall = !sclS && sclP;
  assign startC = sclS && sclP && sdaP && !sdaS;
  assign stopC = sclS && sclP && !sdaP && sdaS;
  assign txByte = iAddrQ[7] ? 8'h00 : rdByte(iAddrQ[6:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iStQ <= hsp_pkg::IC_IDLE;
      iPhQ <= hsp_pkg::PH_DEV;
      iCntQ <= 4'h0;
      iShQ <= 8'h00;
      iAddrQ <= 8'h00;
      iRwQ <= 1'b0;
      sdaOeNQ <= 1'b1;
    end else if (ifSpiQ || stQ == hsp_pkg::MD_STBY) begin
      iStQ <= hsp_pkg::IC_IDLE;
      sdaOeNQ <= 1'b1;
    end else if (startC) begin
      iStQ <= hsp_pkg::IC_RX;
      iPhQ <= hsp_pkg::PH_DEV;
      iCntQ <= 4'h0;
      sdaOeNQ <= 1'b1;
    end else if (stopC) begin
      iStQ <= hsp_pkg::IC_IDLE;
      sdaOeNQ <= 1'b1;
    end else begin
      case (iStQ)
        hsp_pkg::IC_RX: begin
          if (sclRise) begin
            iShQ <= {iShQ[6:0], sdaS};
            iCntQ <= iCntQ + 4'h1;
          end else if (sclFall && iCntQ == hsp_pkg::BYTE_BITS) begin
            iStQ <= hsp_pkg::IC_ACK;
            sdaOeNQ <= 1'b0;
            case (iPhQ)
              hsp_pkg::PH_DEV: begin
                iRwQ <= iShQ[0];
                if (iShQ[7:1] != hsp_pkg::DEV_ADDR || !accessOk) begin
                  iStQ <= hsp_pkg::IC_IDLE;
                  sdaOeNQ <= 1'b1;
                end
              end
              hsp_pkg::PH_REG: iAddrQ <= iShQ;
              default: iAddrQ <= iAddrQ + 8'h01;
            endcase
          end
        end
        hsp_pkg::IC_ACK, hsp_pkg::IC_TXACK: begin
          if (iStQ == hsp_pkg::IC_TXACK && sclRise && sdaS) begin
            iStQ <= hsp_pkg::IC_IDLE;
          end else if (sclFall && iRwQ) begin
            iStQ <= hsp_pkg::IC_TX;
            iShQ <= txByte;
            sdaOeNQ <= txByte[7];
            iCntQ <= 4'h1;
            iAddrQ <= iAddrQ + 8'h01;
          end else if (sclFall) begin
            iStQ <= hsp_pkg::IC_RX;
            iCntQ <= 4'h0;
            sdaOeNQ <= 1'b1;
            iPhQ <= iPhQ == hsp_pkg::PH_DEV ? hsp_pkg::PH_REG : hsp_pkg::PH_DATA;
          end
        end
        hsp_pkg::IC_TX: begin
          if (sclFall && iCntQ == hsp_pkg::BYTE_BITS) begin
            iStQ <= hsp_pkg::IC_TXACK;
            sdaOeNQ <= 1'b1;
          end else if (sclFall) begin
            iShQ <= {iShQ[6:0], 1'b0};
            sdaOeNQ <= iShQ[6];
            iCntQ <= iCntQ + 4'h1;
          end
        end
        default: iStQ <= hsp_pkg::IC_IDLE;
      endcase
    end
  end

  assign spiDataOut = misoQ;
  assign spiDataOeN = spiOeNQ;
  assign i2cSdaOut = sdaOutQ;
  assign i2cSdaOeN = sdaOeNQ;
  assign plSwitchOn = plOnQ;
  assign boostOn = boostOnQ;
  assign sinksOn = sinksOnQ;
  assign faultClear = faultClearQ;
  assign ifIsSpi = ifSpiQ;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_standby_hold: assert property (!enS |=> stQ == hsp_pkg::MD_STBY)
    else $error("not in standby with enable low");
  a_load_copy: assert property (stQ == hsp_pkg::MD_LOAD && enS
    |=> stQ == hsp_pkg::MD_SOFT && cfgQ[0] == nvmQ[0])
    else $error("start-up load missing");
  a_boost_order: assert property ($rose(boostOnQ) |-> $past(plOnQ))
    else $error("boost before power switch");
  a_early_write: assert property (wrEn && !accessOk |=> $stable(unlockQ))
    else $error("write accepted before soft start");
  a_recovery_off: assert property (stQ == hsp_pkg::MD_RECOV
    |=> !plOnQ && !boostOnQ && !sinksOnQ)
    else $error("outputs on in recovery");
  a_cfg_cleared: assert property (stQ == hsp_pkg::MD_STBY |=> cfgQ[0] == 8'h00)
    else $error("front-end kept in standby");
  a_burn_locked: assert property (!$stable(nvmQ[0]) |-> $past(unlocked))
    else $error("burn while locked");
  a_lock_other: assert property (doWr && wrAddr == hsp_pkg::UNLOCK_ADDR
    && wrData != hsp_pkg::PASS1 && wrData != hsp_pkg::PASS2 |=> !unlocked)
    else $error("lock not restored");
  a_strap_hold: assert property (stQ != hsp_pkg::MD_LOAD |=> $stable(ifSpiQ))
    else $error("strap changed outside start-up");
  a_miso_release: assert property (selS |=> spiOeNQ)
    else $error("serial output driven while deselected");
  a_fault_clear: assert property (!ifSpiQ && stQ != hsp_pkg::MD_STBY && (selS ^ selP)
    |=> faultClearQ ##1 !faultClearQ || (selS ^ selP))
    else $error("fault clear pulse wrong");
  a_bad_address: assert property (iStQ == hsp_pkg::IC_RX && sclFall && iPhQ == hsp_pkg::PH_DEV
    && iCntQ == hsp_pkg::BYTE_BITS && iShQ[7:1] != hsp_pkg::DEV_ADDR
    |=> iStQ == hsp_pkg::IC_IDLE && sdaOeNQ)
    else $error("foreign address acknowledged");

  sequence s_nack;
    iStQ == hsp_pkg::IC_TXACK && sclRise && sdaS && !stopC && !ifSpiQ && enS;
  endsequence
  sequence s_released;
    iStQ == hsp_pkg::IC_IDLE && sdaOeNQ;
  endsequence
  a_nack_stop: assert property (s_nack |=> s_released)
    else $error("slave kept driving after nack");

  // Checked on the falling edge after the last bit, while select is still low
  a_spi_write: assert property (@(negedge spiClk) disable iff (rst || spiSelectN)
    sCntQ == hsp_pkg::SPI_END && sDirQ |-> wrTogQ != $past(wrTogQ))
    else $error("spi write not handed over");

endmodule : hsp_top
